// ==== abcc_pkg.sv ====
package abcc_pkg;

    localparam int unsigned BYTE_W = 8;
    localparam int unsigned CHAN_W = 4;
    localparam int unsigned DUAL_W = 6;
    localparam int unsigned MUX_N = 12;

    // Settling and conversion times, in bus clocks.
    localparam int unsigned SETTLE_CLKS = 32;
    localparam int unsigned CONV_CLKS = 256;
    localparam int unsigned RESULT_BITS = 8;

    // Register select decode.
    localparam logic RSEL_NOOP = 1'b0;
    localparam logic RSEL_CTRL = 1'b1;
    localparam logic RSEL_RESULTS = 1'b0;
    localparam logic RSEL_DISCRETE = 1'b1;

    // Control word fields.
    localparam int unsigned CTRL_START_BIT = 0;
    localparam int unsigned CTRL_CHAN_LSB = 0;

    // Results word fields.
    localparam int unsigned RES_FLAG_BIT = 7;

    // Reset values.
    localparam logic [CHAN_W-1:0] CHAN_RESET = 4'h0;
    localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
    localparam logic [MUX_N-1:0] MUX_NONE = 12'h000;
    localparam logic [RESULT_BITS-1:0] SAR_FIRST = 8'h80;

    typedef enum logic [1:0] {
        ABCC_IDLE,
        ABCC_SAMPLE,
        ABCC_CONVERT
    } abcc_state_e;

endpackage : abcc_pkg

// ==== abcc_sar.sv ====
`timescale 1ns/1ps

// Successive approximation register: one trial bit per load, MSB first.
module abcc_sar #(
    parameter int unsigned WIDTH = abcc_pkg::RESULT_BITS
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic clear_i,
    input wire logic load_i,
    input wire logic comparator_i,
    output logic [WIDTH-1:0] trial_code_o,
    output logic [WIDTH-1:0] decided_code_o,
    output logic last_bit_o
);

    logic [WIDTH-1:0] code_r;
    logic [WIDTH-1:0] bit_r;
    logic [WIDTH-1:0] kept;

    initial begin
        if (WIDTH != abcc_pkg::RESULT_BITS) begin
            $error("abcc_sar width must match the result width");
        end
    end

    // A low comparison drops the bit under test.
    assign kept = comparator_i ? code_r : (code_r & ~bit_r);

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            code_r <= abcc_pkg::SAR_FIRST;
            bit_r <= abcc_pkg::SAR_FIRST;
        end else if (clear_i) begin
            code_r <= abcc_pkg::SAR_FIRST;
            bit_r <= abcc_pkg::SAR_FIRST;
        end else if (load_i) begin
            code_r <= kept | (bit_r >> 1);
            bit_r <= bit_r >> 1;
        end
    end

    assign trial_code_o = code_r;
    assign decided_code_o = kept;
    assign last_bit_o = bit_r[0];

endmodule : abcc_sar

// ==== abcc_conv_ctrl.sv ====
`timescale 1ns/1ps

module abcc_conv_ctrl #(
    parameter int unsigned SETTLE_CLKS = abcc_pkg::SETTLE_CLKS,
    parameter int unsigned CONV_CLKS = abcc_pkg::CONV_CLKS
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic dev_sel_n_i,
    input wire logic read_not_write_i,
    input wire logic register_select_line_i,
    input wire logic [abcc_pkg::BYTE_W-1:0] bus_data_lines_i,
    output logic [abcc_pkg::BYTE_W-1:0] bus_data_lines_o,
    output logic bus_data_lines_oe_o,
    input wire logic [abcc_pkg::DUAL_W-1:0] dual_use_inputs_i,
    input wire logic comparator_i,
    output logic [abcc_pkg::MUX_N-1:0] mux_select_o,
    output logic sample_o,
    output logic converting_o,
    output logic [abcc_pkg::RESULT_BITS-1:0] ladder_code_o
);

    localparam int unsigned BIT_CLKS = (CONV_CLKS - SETTLE_CLKS) / abcc_pkg::RESULT_BITS;
    localparam int unsigned CNT_W = 8;

    initial begin
        // The ladder code is registered, so each trial bit needs two clocks to settle.
        if (SETTLE_CLKS < 1 || BIT_CLKS < 2) begin
            $error("abcc_conv_ctrl: conversion time too short for settling and bits");
        end
        if ((CONV_CLKS - SETTLE_CLKS) % abcc_pkg::RESULT_BITS != 0) begin
            $error("abcc_conv_ctrl: bit time must divide the conversion time evenly");
        end
        if (SETTLE_CLKS > (1 << CNT_W) || BIT_CLKS > (1 << CNT_W)) begin
            $error("abcc_conv_ctrl: counts exceed the phase counter");
        end
    end

    localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CLKS - 1);
    localparam logic [CNT_W-1:0] BIT_LAST = CNT_W'(BIT_CLKS - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;

    // Maps channel codes 0-5 and A-F onto one leg of the 12-to-1 multiplexer; codes 6-9 select no leg.
    function automatic logic [abcc_pkg::MUX_N-1:0] chan_onehot(
        input logic [abcc_pkg::CHAN_W-1:0] code
    );
        logic [abcc_pkg::MUX_N-1:0] sel;
        sel = abcc_pkg::MUX_NONE;
        case (code)
            4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5: sel[code] = 1'b1;
            4'hA: sel[10] = 1'b1;
            4'hB: sel[11] = 1'b1;
            4'hC: sel[8] = 1'b1;
            4'hD: sel[9] = 1'b1;
            4'hE: sel[6] = 1'b1;
            4'hF: sel[7] = 1'b1;
            default: sel = abcc_pkg::MUX_NONE;
        endcase
        return sel;
    endfunction : chan_onehot

    // Reset release synchroniser.
    logic [1:0] rst_sync_r;
    logic rst_n;

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_r[1];

    // Bus decode. Every access is taken at the clock edge while select is low.
    logic access;
    logic wr_access;
    logic rd_access;
    logic byte_upper_r;
    logic [abcc_pkg::BYTE_W-1:0] upper_hold_r;
    logic ctrl_word_done;

    assign access = !dev_sel_n_i;
    assign wr_access = access && !read_not_write_i;
    assign rd_access = access && read_not_write_i;
    assign ctrl_word_done = wr_access && !byte_upper_r
        && (register_select_line_i == abcc_pkg::RSEL_CTRL);

    // Byte counter: upper first, then lower, then back to upper.
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            byte_upper_r <= 1'b1;
        end else if (!access) begin
            byte_upper_r <= 1'b1;
        end else begin
            byte_upper_r <= !byte_upper_r;
        end
    end

    // Upper control byte is held until its lower byte completes the word.
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            upper_hold_r <= abcc_pkg::BYTE_ZERO;
        end else if (wr_access && byte_upper_r
                     && register_select_line_i == abcc_pkg::RSEL_CTRL) begin
            upper_hold_r <= bus_data_lines_i;
        end
    end

    // Control word: channel field and start request.
    logic [abcc_pkg::CHAN_W-1:0] channel_address_field_r;
    logic begin_conversion_request_r;
    logic start_taken;

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            channel_address_field_r <= abcc_pkg::CHAN_RESET;
        end else if (ctrl_word_done) begin
            channel_address_field_r <=
                bus_data_lines_i[abcc_pkg::CTRL_CHAN_LSB +: abcc_pkg::CHAN_W];
        end
    end

    // A fresh write wins over the sequencer's own clear of the request.
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            begin_conversion_request_r <= 1'b0;
        end else if (ctrl_word_done) begin
            begin_conversion_request_r <= upper_hold_r[abcc_pkg::CTRL_START_BIT];
        end else if (start_taken) begin
            begin_conversion_request_r <= 1'b0;
        end
    end

    // Conversion sequencer.
    abcc_pkg::abcc_state_e state_r;
    logic [CNT_W-1:0] phase_cnt_r;
    logic sar_clear;
    logic sar_load;
    logic conv_finish;
    logic [abcc_pkg::RESULT_BITS-1:0] trial_code;
    logic [abcc_pkg::RESULT_BITS-1:0] decided_code;
    logic last_bit;

    assign start_taken = begin_conversion_request_r;
    assign sar_clear = start_taken;
    assign sar_load = (state_r == abcc_pkg::ABCC_CONVERT)
        && (phase_cnt_r == BIT_LAST) && !start_taken;
    assign conv_finish = sar_load && last_bit;

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= abcc_pkg::ABCC_IDLE;
            phase_cnt_r <= CNT_ZERO;
        end else if (start_taken) begin
            state_r <= abcc_pkg::ABCC_SAMPLE;
            phase_cnt_r <= CNT_ZERO;
        end else begin
            case (state_r)
                abcc_pkg::ABCC_IDLE: begin
                    state_r <= abcc_pkg::ABCC_IDLE;
                    phase_cnt_r <= CNT_ZERO;
                end
                abcc_pkg::ABCC_SAMPLE: begin
                    if (phase_cnt_r == SETTLE_LAST) begin
                        state_r <= abcc_pkg::ABCC_CONVERT;
                        phase_cnt_r <= CNT_ZERO;
                    end else begin
                        phase_cnt_r <= phase_cnt_r + 8'h01;
                    end
                end
                abcc_pkg::ABCC_CONVERT: begin
                    if (conv_finish) begin
                        state_r <= abcc_pkg::ABCC_IDLE;
                        phase_cnt_r <= CNT_ZERO;
                    end else if (phase_cnt_r == BIT_LAST) begin
                        phase_cnt_r <= CNT_ZERO;
                    end else begin
                        phase_cnt_r <= phase_cnt_r + 8'h01;
                    end
                end
                default: begin
                    state_r <= abcc_pkg::ABCC_IDLE;
                    phase_cnt_r <= CNT_ZERO;
                end
            endcase
        end
    end

    abcc_sar #(
        .WIDTH(abcc_pkg::RESULT_BITS)
    ) u_sar (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n),
        .clear_i(sar_clear),
        .load_i(sar_load),
        .comparator_i(comparator_i),
        .trial_code_o(trial_code),
        .decided_code_o(decided_code),
        .last_bit_o(last_bit)
    );

    // Data register keeps its contents through reset.
    logic [abcc_pkg::RESULT_BITS-1:0] conversion_result_bits_r;

    always_ff @(posedge sys_clk_i) begin
        if (conv_finish) begin
            conversion_result_bits_r <= decided_code;
        end
    end

    // Completion flag: set on the same edge the result lands; set beats clear.
    logic result_valid_r;

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            result_valid_r <= 1'b0;
        end else if (conv_finish) begin
            result_valid_r <= 1'b1;
        end else if (ctrl_word_done) begin
            result_valid_r <= 1'b0;
        end
    end

    // Read multiplexer for the two readable words.
    logic [abcc_pkg::DUAL_W-1:0] dual_level_r;
    logic [abcc_pkg::BYTE_W-1:0] rd_byte;

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            dual_level_r <= '0;
        end else begin
            dual_level_r <= dual_use_inputs_i;
        end
    end

    always_comb begin
        rd_byte = abcc_pkg::BYTE_ZERO;
        if (register_select_line_i == abcc_pkg::RSEL_RESULTS) begin
            if (byte_upper_r) begin
                rd_byte[abcc_pkg::RES_FLAG_BIT] = result_valid_r;
            end else begin
                rd_byte = conversion_result_bits_r;
            end
        end else begin
            if (byte_upper_r) begin
                rd_byte[abcc_pkg::CHAN_W-1:0] = channel_address_field_r;
            end else begin
                rd_byte[abcc_pkg::DUAL_W-1:0] = dual_level_r;
            end
        end
    end

    // Data lines are driven for the cycle after each read access only.
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            bus_data_lines_oe_o <= 1'b0;
            bus_data_lines_o <= abcc_pkg::BYTE_ZERO;
        end else begin
            bus_data_lines_oe_o <= rd_access;
            if (rd_access) begin
                bus_data_lines_o <= rd_byte;
            end
        end
    end

    // Analog front end controls.
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            mux_select_o <= abcc_pkg::MUX_NONE;
            sample_o <= 1'b0;
            converting_o <= 1'b0;
            ladder_code_o <= abcc_pkg::SAR_FIRST;
        end else begin
            mux_select_o <= chan_onehot(channel_address_field_r);
            sample_o <= (state_r == abcc_pkg::ABCC_SAMPLE);
            converting_o <= (state_r != abcc_pkg::ABCC_IDLE);
            ladder_code_o <= trial_code;
        end
    end

endmodule : abcc_conv_ctrl

// ==== abcc_analog_model.sv ====
`timescale 1ns/1ps

// Analog front end: every multiplexer leg carries a fixed level, and the comparator
// reports whether the selected level reaches the ladder tap. With no leg selected the output is low.
module abcc_analog_model (
    input wire logic [abcc_pkg::MUX_N-1:0] mux_select_i,
    input wire logic [abcc_pkg::RESULT_BITS-1:0] ladder_code_i,
    output logic comparator_o
);
    logic [abcc_pkg::RESULT_BITS-1:0] level;
    logic hit;
    always_comb begin
        level = 8'h00;
        hit = 1'b0;
        for (int k = 0; k < abcc_pkg::MUX_N; k++) begin
            if (mux_select_i[k]) begin
                level = {k[3:0], 4'h6};
                hit = 1'b1;
            end
        end
        comparator_o = hit && (level >= ladder_code_i);
    end
endmodule : abcc_analog_model

// ==== abcc_conv_ctrl_checker.sv ====
`timescale 1ns/1ps

module abcc_conv_ctrl_checker #(
    parameter int unsigned SETTLE_CLKS = abcc_pkg::SETTLE_CLKS,
    parameter int unsigned CONV_CLKS = abcc_pkg::CONV_CLKS
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic dev_sel_n_i,
    input wire logic read_not_write_i,
    input wire logic register_select_line_i,
    input wire logic [abcc_pkg::BYTE_W-1:0] bus_data_lines_i,
    input wire logic [abcc_pkg::BYTE_W-1:0] bus_data_lines_o,
    input wire logic bus_data_lines_oe_o,
    input wire logic [abcc_pkg::MUX_N-1:0] mux_select_o,
    input wire logic sample_o,
    input wire logic converting_o
);
    logic rd_acc;
    logic ctrl_wr;
    logic lower_r;
    logic res_hi_r;
    logic samp_q_r;
    logic [15:0] samp_cnt_r;
    logic [15:0] conv_cnt_r;
    logic hold_start_r;
    logic [2:0] restart_r;
    logic restart;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    assign rd_acc = !dev_sel_n_i && read_not_write_i;
    assign ctrl_wr = !dev_sel_n_i && !read_not_write_i && register_select_line_i;
    // A completed control word with the start bit restarts acquisition three edges later.
    assign restart = ctrl_wr && lower_r && hold_start_r;
    // Byte position and run lengths of the sample and busy levels.
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lower_r <= 1'b0;
            res_hi_r <= 1'b0;
            samp_q_r <= 1'b0;
            samp_cnt_r <= 16'h0000;
            conv_cnt_r <= 16'h0000;
            hold_start_r <= 1'b0;
            restart_r <= 3'h0;
        end else begin
            lower_r <= !dev_sel_n_i && !lower_r;
            res_hi_r <= rd_acc && !register_select_line_i && !lower_r;
            samp_q_r <= sample_o;
            if (ctrl_wr && !lower_r) begin
                hold_start_r <= bus_data_lines_i[abcc_pkg::CTRL_START_BIT];
            end
            restart_r <= {restart_r[1:0], restart};
            samp_cnt_r <= restart_r[2] ? 16'h0001 :
                (sample_o ? samp_cnt_r + 16'h0001 : 16'h0000);
            conv_cnt_r <= (restart_r[2] || (sample_o && !samp_q_r)) ? 16'h0001 :
                (converting_o ? conv_cnt_r + 16'h0001 : 16'h0000);
        end
    end
    property p_reset;
        disable iff (1'b0) !rst_n_i |-> !bus_data_lines_oe_o && !sample_o && !converting_o
            && mux_select_o == 12'h000;
    endproperty
    a_reset: assert property (p_reset) else $error("outputs active in reset");
    property p_oe_read;
        bus_data_lines_oe_o |-> $past(rd_acc);
    endproperty
    a_oe_read: assert property (p_oe_read) else $error("drive without read");
    property p_sel_refuse;
        dev_sel_n_i |=> !bus_data_lines_oe_o;
    endproperty
    a_sel_refuse: assert property (p_sel_refuse) else $error("answer while unselected");
    property p_read_answer;
        rd_acc |=> bus_data_lines_oe_o;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read not answered");
    property p_samp_len;
        $fell(sample_o) |-> samp_cnt_r == SETTLE_CLKS;
    endproperty
    a_samp_len: assert property (p_samp_len) else $error("sampling length wrong");
    property p_conv_len;
        $fell(converting_o) |-> conv_cnt_r == CONV_CLKS;
    endproperty
    a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");
    property p_start_cause;
        $rose(sample_o) |-> $past(ctrl_wr, 3);
    endproperty
    a_start_cause: assert property (p_start_cause) else $error("start without write");
    property p_onehot;
        $onehot0(mux_select_o);
    endproperty
    a_onehot: assert property (p_onehot) else $error("several legs selected");
    property p_res_upper;
        res_hi_r |-> bus_data_lines_o[6:0] == 7'h00;
    endproperty
    a_res_upper: assert property (p_res_upper) else $error("status byte not zero");
endmodule : abcc_conv_ctrl_checker

bind abcc_conv_ctrl abcc_conv_ctrl_checker #(.SETTLE_CLKS(SETTLE_CLKS), .CONV_CLKS(CONV_CLKS))
    u_abcc_conv_ctrl_checker (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .dev_sel_n_i(dev_sel_n_i), .read_not_write_i(read_not_write_i),
    .register_select_line_i(register_select_line_i), .bus_data_lines_i(bus_data_lines_i),
    .bus_data_lines_o(bus_data_lines_o),
    .bus_data_lines_oe_o(bus_data_lines_oe_o), .mux_select_o(mux_select_o),
    .sample_o(sample_o), .converting_o(converting_o));

// ==== test_adc_bus_conversion_control.sv ====
`timescale 1ns/1ps

module test_adc_bus_conversion_control;
    logic sys_clk_i = 1'b0;
    logic rst_n_i = 1'b1;
    logic sel_n = 1'b1;
    logic rnw = 1'b0;
    logic rsel = 1'b0;
    logic [7:0] hdrv = 8'h00;
    logic [5:0] dual = 6'h2D;
    logic [7:0] bus_w;
    logic [7:0] dout;
    logic oe;
    logic cmp;
    logic smp;
    logic conv;
    logic [11:0] mux;
    logic [7:0] lad;
    logic [7:0] hi;
    logic [7:0] lo;
    int bad_count = 0;
    int num_checks = 0;
    assign bus_w = oe ? dout : hdrv;
    initial forever #5 sys_clk_i = ~sys_clk_i;
    abcc_conv_ctrl #(.SETTLE_CLKS(8), .CONV_CLKS(24)) u_abcc_conv_ctrl (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .dev_sel_n_i(sel_n),
        .read_not_write_i(rnw), .register_select_line_i(rsel), .bus_data_lines_i(bus_w),
        .bus_data_lines_o(dout), .bus_data_lines_oe_o(oe), .dual_use_inputs_i(dual),
        .comparator_i(cmp), .mux_select_o(mux), .sample_o(smp), .converting_o(conv),
        .ladder_code_o(lad));
    abcc_analog_model u_abcc_analog_model (.mux_select_i(mux), .ladder_code_i(lad),
        .comparator_o(cmp));
    task automatic step();
        @(posedge sys_clk_i);
        #1;
    endtask : step
    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk8
    task automatic chk12(input string what, input logic [11:0] exp, input logic [11:0] got);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk12
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : results
    // Bytes go on consecutive edges; select then stays high a full cycle.
    task automatic wr(input logic rs, input logic [7:0] up, input logic [7:0] low, input bit two);
        sel_n = 1'b0;
        rnw = 1'b0;
        rsel = rs;
        hdrv = up;
        step();
        if (two) begin
            hdrv = low;
            step();
        end
        sel_n = 1'b1;
        hdrv = ~hdrv;
        step();
    endtask : wr
    task automatic rd(input logic rs, input bit two);
        sel_n = 1'b0;
        rnw = 1'b1;
        rsel = rs;
        hdrv = ~hdrv;
        step();
        chk8("drive enable", 8'h01, {7'h00, oe});
        hi = dout;
        if (two) begin
            step();
            chk8("drive enable", 8'h01, {7'h00, oe});
            lo = dout;
        end
        sel_n = 1'b1;
        rnw = 1'b0;
        step();
        chk8("drive enable", 8'h00, {7'h00, oe});
    endtask : rd
    task automatic flag(input logic [7:0] exp);
        rd(1'b0, 1'b0);
        chk8("status byte", exp, hi);
    endtask : flag
    task automatic start(input logic [3:0] code);
        wr(1'b1, 8'h01, {4'h0, code}, 1'b1);
    endtask : start
    task automatic finish(input logic [7:0] exp);
        int n;
        n = 0;
        hi = 8'h00;
        while (hi[7] !== 1'b1) begin
            if (n == 40) begin
                bad_count++;
                results();
            end
            n++;
            rd(1'b0, 1'b0);
        end
        rd(1'b0, 1'b1);
        chk8("status byte", 8'h80, hi);
        chk8("result byte", exp, lo);
    endtask : finish
    function automatic logic [11:0] mux_exp(input logic [3:0] code);
        case (code)
            4'h6, 4'h7, 4'h8, 4'h9: return 12'h000;
            4'hA: return 12'h400;
            4'hB: return 12'h800;
            4'hC: return 12'h100;
            4'hD: return 12'h200;
            4'hE: return 12'h040;
            4'hF: return 12'h080;
            default: return 12'h001 << code;
        endcase
    endfunction : mux_exp
    initial begin
        #1 rst_n_i = 1'b0;
        repeat (4) step();
        chk8("drive enable", 8'h00, {7'h00, oe});
        chk8("ladder", 8'h80, lad);
        chk8("busy", 8'h00, {6'h00, smp, conv});
        repeat (2) step();
        rst_n_i = 1'b1;
        repeat (4) step();
        chk12("mux", 12'h001, mux);
        flag(8'h00);
        $display("end of test reset");
        rd(1'b1, 1'b1);
        chk8("discrete upper", 8'h00, hi);
        chk8("discrete lower", 8'h2D, lo);
        dual = 6'h12;
        step();
        rd(1'b1, 1'b1);
        chk8("discrete lower", 8'h12, lo);
        for (int c = 0; c < 16; c++) begin
            wr(1'b1, 8'h00, c[7:0], 1'b1);
            step();
            chk12("mux", mux_exp(c[3:0]), mux);
            chk8("busy", 8'h00, {6'h00, smp, conv});
            rd(1'b1, 1'b0);
            chk8("discrete upper", c[7:0], hi);
        end
        $display("end of test channel select");
        start(4'h5);
        repeat (2) step();
        chk8("busy", 8'h03, {6'h00, smp, conv});
        finish(8'h56);
        rd(1'b0, 1'b1);
        chk8("status byte", 8'h80, hi);
        wr(1'b0, 8'h00, 8'h00, 1'b1);
        flag(8'h80);
        wr(1'b1, 8'h00, 8'h00, 1'b0);
        flag(8'h80);
        rsel = 1'b1;
        hdrv = 8'h01;
        repeat (3) step();
        flag(8'h80);
        wr(1'b1, 8'h00, 8'h00, 1'b1);
        flag(8'h00);
        start(4'hA);
        finish(8'hA6);
        $display("end of test conversion");
        start(4'h2);
        repeat (12) step();
        start(4'h3);
        repeat (10) step();
        flag(8'h00);
        finish(8'h36);
        $display("end of test abort");
        rst_n_i = 1'b0;
        repeat (3) step();
        chk8("drive enable", 8'h00, {7'h00, oe});
        chk8("busy", 8'h00, {6'h00, smp, conv});
        chk12("mux", 12'h000, mux);
        rst_n_i = 1'b1;
        repeat (4) step();
        chk12("mux", 12'h001, mux);
        rd(1'b0, 1'b1);
        chk8("status byte", 8'h00, hi);
        chk8("result byte", 8'h36, lo);
        $display("end of test mid-run reset");
        results();
    end
endmodule : test_adc_bus_conversion_control
